// file: logic/nvmc_pkg.sv
// Package: register map, field positions, command and mode codes of the memory controller
package nvmc_pkg;
    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [3:0] IDX_CMD = 4'h0;
    localparam logic [3:0] IDX_PROT = 4'h1;
    localparam logic [3:0] IDX_STAT = 4'h2;
    localparam logic [3:0] IDX_IEN = 4'h3;
    localparam logic [3:0] IDX_IFLAG = 4'h4;
    localparam logic [3:0] IDX_DATA_L = 4'h6;
    localparam logic [3:0] IDX_DATA_H = 4'h7;
    localparam logic [3:0] IDX_ADDR_L = 4'h8;
    localparam logic [3:0] IDX_ADDR_H = 4'h9;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_APP_WP = 0;
    localparam int BIT_BOOT_LOCK = 1;
    localparam int BIT_FLASH_BUSY = 0;
    localparam int BIT_EE_BUSY = 1;
    localparam int BIT_WERR = 2;
    localparam int BIT_READY = 0;
    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [2:0] RST_CMD = 3'h0;
    localparam logic [2:0] UNLOCK_INSTR = 3'h4;
    localparam logic [2:0] CLEAR_CYCLES = 3'h7;
    localparam logic [7:0] READY_VECTOR = 8'h00;
    // ----------------------------------------
    // Commands, sleep modes, sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_PAGE_WRITE = 3'h1,
        CMD_PAGE_ERASE = 3'h2,
        CMD_ERASE_WRITE = 3'h3,
        CMD_BUF_CLEAR = 3'h4,
        CMD_FULL_ERASE = 3'h5,
        CMD_EE_ERASE = 3'h6,
        CMD_FUSE_PROG = 3'h7
    } nvmc_cmd_t;
    typedef enum logic [1:0] {
        SLP_IDLE = 2'h0,
        SLP_STANDBY = 2'h1,
        SLP_POWERDOWN = 2'h2
    } nvmc_sleep_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLEAR,
        ST_ARRAY
    } nvmc_st_t;
endpackage

// file: logic/nvmc_memory_controller.sv
// Memory controller: command register, protection, status, ready interrupt and sleep control
`timescale 1ns/10ps
`default_nettype none
module nvmc_memory_controller
    import nvmc_pkg::*;
#(
    parameter logic [15:0] BOOT_END = 16'h1000,
    parameter logic [15:0] FLASH_BASE = 16'h8000,
    parameter logic [15:0] EE_BASE = 16'h1400,
    parameter logic [15:0] EE_END = 16'h1500
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dbg_port_sel,
    input wire logic unlock_key,
    input wire logic instr_retire,
    input wire logic [15:0] fetch_addr,
    input wire logic [15:0] rd_addr,
    input wire logic [7:0] rd_data_raw,
    output logic [7:0] rd_data_q,
    input wire logic buf_load,
    input wire logic [15:0] buf_load_addr,
    input wire logic buf_mixed,
    input wire logic eeprom_preserve_fuse,
    input wire logic array_done,
    input wire logic sleep_req,
    input wire logic [1:0] sleep_mode,
    output logic cmd_start_q,
    output logic [2:0] cmd_code_q,
    output logic cmd_eeprom_q,
    output logic cmd_ee_incl_q,
    output logic [15:0] fuse_data_q,
    output logic [15:0] target_addr_q,
    output logic buf_clear_q,
    output logic cpu_halt_q,
    output logic irq_q,
    output logic wake_q,
    output logic ctrl_sleep_q,
    output logic keep_clock_q
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        nvmc_st_t st;
        logic [2:0] cnt;
        logic [2:0] win;
        logic [2:0] cmd;
        logic lock_pend;
        logic lock_on;
        logic app_wp;
        logic werr;
        logic ee_busy;
        logic f_busy;
        logic ien;
        logic flag;
        logic [15:0] data;
        logic [15:0] addr;
        logic rdy;
        logic err;
        logic [7:0] rdat;
        logic start;
        logic [2:0] code;
        logic ee_tgt;
        logic ee_incl;
        logic clr;
        logic halt;
        logic irq;
        logic wake;
        logic slp;
        logic keep;
        logic slp_prev;
        logic [7:0] mdat;
    } nvmc_state_t;

    nvmc_state_t q;
    nvmc_state_t d;
    logic acc;
    logic done;
    logic wr;
    logic [3:0] idx;
    logic mapped;
    logic in_boot_fetch;
    logic busy;
    logic ee_hit;
    logic app_hit;
    logic [2:0] wcmd;
    logic ok_cmd;

    function automatic logic in_boot(input logic [15:0] a);
        in_boot = (a >= FLASH_BASE) && (a < FLASH_BASE + BOOT_END);
    endfunction

    assign acc = psel && penable;
    assign done = acc && q.rdy;
    assign wr = done && pwrite && !q.err;
    assign idx = paddr[5:2];
    assign mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (idx != 4'h5) && (idx <= IDX_ADDR_H);
    assign in_boot_fetch = in_boot(fetch_addr);
    assign busy = q.ee_busy || q.f_busy || (q.st != ST_IDLE);
    assign ee_hit = (q.addr >= EE_BASE) && (q.addr < EE_END);
    assign app_hit = (q.addr >= FLASH_BASE + BOOT_END);
    assign wcmd = pwdata[2:0];
    // Key opens a window; the fuse code also needs the debug port as master
    assign ok_cmd = (q.win != 3'h0) && (wcmd != CMD_FUSE_PROG || dbg_port_sel);

    always_comb begin
        d = q;
        d.start = 1'b0;
        d.clr = 1'b0;
        d.slp_prev = sleep_req;
        // ----------------------------------------
        // APB: one wait state so read data comes from a flop
        // ----------------------------------------
        d.rdy = acc && !q.rdy;
        d.err = acc && !q.rdy && !mapped;
        d.rdat = RST_BYTE;
        if (acc && !q.rdy && !pwrite) begin
            if (idx == IDX_CMD) begin
                d.rdat = {5'h00, q.cmd};
            end else if (idx == IDX_PROT) begin
                d.rdat[BIT_BOOT_LOCK] = q.lock_pend;
                d.rdat[BIT_APP_WP] = q.app_wp;
            end else if (idx == IDX_STAT) begin
                d.rdat[BIT_WERR] = q.werr;
                d.rdat[BIT_EE_BUSY] = q.ee_busy;
                d.rdat[BIT_FLASH_BUSY] = q.f_busy;
            end else if (idx == IDX_IEN) begin
                d.rdat[BIT_READY] = q.ien;
            end else if (idx == IDX_IFLAG) begin
                d.rdat[BIT_READY] = q.flag;
            end else if (idx == IDX_DATA_L) begin
                d.rdat = q.data[7:0];
            end else if (idx == IDX_DATA_H) begin
                d.rdat = q.data[15:8];
            end else if (idx == IDX_ADDR_L) begin
                d.rdat = q.addr[7:0];
            end else if (idx == IDX_ADDR_H) begin
                d.rdat = q.addr[15:8];
            end
        end
        // ----------------------------------------
        // Unlock window, counted in retired instructions
        // ----------------------------------------
        if (unlock_key) begin
            d.win = UNLOCK_INSTR;
        end else if (instr_retire && q.win != 3'h0) begin
            d.win = q.win - 3'h1;
        end
        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (wr) begin
            if (idx == IDX_CMD) begin
                if (ok_cmd) begin
                    d.cmd = wcmd;
                    d.win = 3'h0;
                end
            end else if (idx == IDX_PROT) begin
                if (pwdata[BIT_BOOT_LOCK] && in_boot_fetch) begin
                    d.lock_pend = 1'b1;
                end
                if (pwdata[BIT_APP_WP]) begin
                    d.app_wp = 1'b1;
                end
            end else if (idx == IDX_IEN) begin
                d.ien = pwdata[BIT_READY];
            end else if (idx == IDX_DATA_L) begin
                d.data[7:0] = pwdata[7:0];
            end else if (idx == IDX_DATA_H) begin
                d.data[15:8] = pwdata[7:0];
            end else if (idx == IDX_ADDR_L) begin
                d.addr[7:0] = pwdata[7:0];
            end else if (idx == IDX_ADDR_H) begin
                d.addr[15:8] = pwdata[7:0];
            end
        end
        // Buffer loads overwrite an IDX_ADDR_L or IDX_ADDR_H register write in the same cycle
        if (buf_load) begin
            d.addr = buf_load_addr;
        end
        // Lock arms only once execution is outside the boot section
        if (q.lock_pend && !in_boot_fetch) begin
            d.lock_on = 1'b1;
        end
        // ----------------------------------------
        // Command sequencer
        // ----------------------------------------
        if (array_done) begin
            d.ee_busy = 1'b0;
            d.f_busy = 1'b0;
        end
        case (q.st)
            ST_IDLE: begin
                // Commands arriving while busy are dropped, not queued
                if (wr && idx == IDX_CMD && ok_cmd && !busy) begin
                    d.code = wcmd;
                    d.ee_tgt = 1'b0;
                    d.ee_incl = 1'b0;
                    case (wcmd)
                        CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_WRITE: begin
                            if (buf_mixed || (!ee_hit && app_hit && q.app_wp)) begin
                                d.werr = 1'b1;
                            end else begin
                                d.werr = 1'b0;
                                d.start = 1'b1;
                                d.ee_tgt = ee_hit;
                                d.ee_busy = ee_hit;
                                d.f_busy = !ee_hit;
                                d.st = ST_ARRAY;
                            end
                        end
                        CMD_BUF_CLEAR: begin
                            d.werr = 1'b0;
                            d.clr = 1'b1;
                            d.cnt = CLEAR_CYCLES;
                            d.st = ST_CLEAR;
                        end
                        CMD_FULL_ERASE: begin
                            // Protection bits do not guard a full erase
                            d.werr = 1'b0;
                            d.start = 1'b1;
                            d.ee_incl = !eeprom_preserve_fuse;
                            d.ee_busy = !eeprom_preserve_fuse;
                            d.f_busy = 1'b1;
                            d.st = ST_ARRAY;
                        end
                        CMD_EE_ERASE: begin
                            d.werr = 1'b0;
                            d.start = 1'b1;
                            d.ee_tgt = 1'b1;
                            d.ee_incl = 1'b1;
                            d.ee_busy = 1'b1;
                            d.st = ST_ARRAY;
                        end
                        CMD_FUSE_PROG: begin
                            d.werr = 1'b0;
                            d.start = 1'b1;
                            d.f_busy = 1'b1;
                            d.st = ST_ARRAY;
                        end
                        default: begin
                            d.werr = q.werr;
                        end
                    endcase
                end
            end
            ST_CLEAR: begin
                d.cnt = q.cnt - 3'h1;
                if (q.cnt == 3'h1) begin
                    d.st = ST_IDLE;
                end
            end
            ST_ARRAY: begin
                if (array_done) begin
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        // EEPROM erase halts the core like a flash operation
        d.halt = (d.st == ST_CLEAR) || d.f_busy || (d.ee_busy && d.code == CMD_EE_ERASE);
        // ----------------------------------------
        // Ready flag and interrupt
        // ----------------------------------------
        d.flag = q.flag;
        if (wr && idx == IDX_IFLAG && pwdata[BIT_READY]) begin
            d.flag = 1'b0;
        end
        if (!q.ee_busy) begin
            d.flag = 1'b1;
        end
        // Level request; software must mask it once serviced
        d.irq = q.ien && q.flag;
        // ----------------------------------------
        // Sleep and wake
        // ----------------------------------------
        d.slp = sleep_req && !busy;
        d.keep = sleep_req && busy;
        d.wake = sleep_req && q.irq && (sleep_mode == SLP_IDLE);
        if (q.slp_prev && !sleep_req) begin
            d.clr = 1'b1;
        end
        // ----------------------------------------
        // Boot section read masking
        // ----------------------------------------
        d.mdat = (q.lock_on && in_boot(rd_addr)) ? RST_BYTE : rd_data_raw;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: ST_IDLE, cnt: RST_CMD, win: RST_CMD, cmd: RST_CMD, data: RST_WORD,
                   addr: RST_WORD, rdat: RST_BYTE, code: RST_CMD, mdat: RST_BYTE, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign prdata = {24'h000000, q.rdat};
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign rd_data_q = q.mdat;
    assign cmd_start_q = q.start;
    assign cmd_code_q = q.code;
    assign cmd_eeprom_q = q.ee_tgt;
    assign cmd_ee_incl_q = q.ee_incl;
    assign fuse_data_q = q.data;
    assign target_addr_q = q.addr;
    assign buf_clear_q = q.clr;
    assign cpu_halt_q = q.halt;
    assign irq_q = q.irq;
    assign wake_q = q.wake;
    assign ctrl_sleep_q = q.slp;
    assign keep_clock_q = q.keep;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_clear_entry;
        (q.st == ST_IDLE) ##1 (q.st == ST_CLEAR);
    endsequence
    sequence s_locked_cmd_write;
        wr && (idx == IDX_CMD) && (q.win == 3'h0) && !unlock_key;
    endsequence

    property p_irq;
        q.ien && q.flag |=> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("ready irq not raised");
    property p_sleep;
        sleep_req && !busy |=> ctrl_sleep_q && !keep_clock_q;
    endproperty
    a_sleep: assert property (p_sleep) else $error("idle controller did not sleep");
    property p_keep;
        sleep_req && busy |=> keep_clock_q && !ctrl_sleep_q;
    endproperty
    a_keep: assert property (p_keep) else $error("clock dropped during write");
    property p_wake;
        wake_q |-> $past(sleep_mode) == SLP_IDLE && $past(q.irq);
    endproperty
    a_wake: assert property (p_wake) else $error("wake outside idle sleep");
    property p_wake_clear;
        $fell(sleep_req) |=> buf_clear_q;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("buffer not cleared on wake");
    property p_locked;
        s_locked_cmd_write |=> $stable(q.cmd) && !cmd_start_q;
    endproperty
    a_locked: assert property (p_locked) else $error("command taken without unlock");
    property p_fuse_cpu;
        wr && (idx == IDX_CMD) && (wcmd == CMD_FUSE_PROG) && !dbg_port_sel |=> !cmd_start_q;
    endproperty
    a_fuse_cpu: assert property (p_fuse_cpu) else $error("fuse write from core");
    property p_clear7;
        s_clear_entry |-> cpu_halt_q [*7] ##1 (q.st == ST_IDLE);
    endproperty
    a_clear7: assert property (p_clear7) else $error("buffer clear halt not seven cycles");
    property p_ready_idle;
        !q.ee_busy |=> q.flag;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready flag low while idle");
    property p_status;
        acc && !q.rdy && !pwrite && (idx == IDX_STAT) |=> prdata[BIT_EE_BUSY] == $past(q.ee_busy);
    endproperty
    a_status: assert property (p_status) else $error("busy bit misreported");
    property p_boot_mask;
        q.lock_on && in_boot(rd_addr) |=> rd_data_q == RST_BYTE;
    endproperty
    a_boot_mask: assert property (p_boot_mask) else $error("locked boot read not zero");
endmodule
`default_nettype wire

// file: logic/nvmc_unused_placeholder_none.sv
// Empty compilation unit kept intentionally minimal
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: sim/nvmc_array_model.sv
// Far-side array model: finishes every started command after a fixed delay
`timescale 1ns/10ps
`default_nettype none
module nvmc_array_model #(
    parameter int DONE_DELAY = 30
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_start_q,
    output logic array_done
);
    int cnt_q;
    // ----------------------------------------
    // Busy countdown
    // ----------------------------------------
    // A reset aborts a running operation, as the real array does
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 0;
            array_done <= 1'b0;
        end else begin
            array_done <= (cnt_q == 1);
            if (cmd_start_q) begin
                cnt_q <= DONE_DELAY;
            end else if (cnt_q != 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the memory controller
`timescale 1ns/10ps
`default_nettype none
module testbench
    import nvmc_pkg::*;
;
    typedef struct packed {logic [3:0] idx; logic [7:0] wd; logic [7:0] exp;} nvmc_row_t;
    nvmc_row_t rows [4] = '{'{IDX_DATA_L, 8'hA5, 8'hA5}, '{IDX_DATA_H, 8'h3C, 8'h3C},
        '{IDX_ADDR_L, 8'h5A, 8'h5A}, '{IDX_ADDR_H, 8'hC3, 8'hC3}};
    logic [3:0] regs [5] = '{IDX_CMD, IDX_PROT, IDX_STAT, IDX_IEN, IDX_IFLAG};
    logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, dbg_port_sel = 0;
    logic unlock_key = 0, instr_retire = 0, buf_load = 0, buf_mixed = 0, eeprom_preserve_fuse = 0;
    logic sleep_req = 0, pready, pslverr, cmd_start_q, cmd_eeprom_q, cmd_ee_incl_q, buf_clear_q;
    logic cpu_halt_q, irq_q, wake_q, ctrl_sleep_q, keep_clock_q, array_done, last_ee, last_incl, er;
    logic [7:0] paddr = 8'h00, rd_data_raw = 8'h5E, rd_data_q, rd;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [15:0] fetch_addr = 16'h8100, rd_addr = 16'h8010, buf_load_addr = 16'h0000;
    logic [15:0] fuse_data_q, target_addr_q;
    logic [1:0] sleep_mode = 2'h0;
    logic [2:0] cmd_code_q, last_code;
    int n_mismatch = 0, n_tests = 0, n_start = 0, n_clr = 0, n_halt = 0, cyc = 0, s, h;

    nvmc_memory_controller i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dbg_port_sel(dbg_port_sel), .unlock_key(unlock_key),
        .instr_retire(instr_retire), .fetch_addr(fetch_addr), .rd_addr(rd_addr),
        .rd_data_raw(rd_data_raw), .rd_data_q(rd_data_q), .buf_load(buf_load),
        .buf_load_addr(buf_load_addr), .buf_mixed(buf_mixed), .eeprom_preserve_fuse(eeprom_preserve_fuse),
        .array_done(array_done), .sleep_req(sleep_req), .sleep_mode(sleep_mode),
        .cmd_start_q(cmd_start_q), .cmd_code_q(cmd_code_q), .cmd_eeprom_q(cmd_eeprom_q),
        .cmd_ee_incl_q(cmd_ee_incl_q), .fuse_data_q(fuse_data_q), .target_addr_q(target_addr_q),
        .buf_clear_q(buf_clear_q), .cpu_halt_q(cpu_halt_q), .irq_q(irq_q), .wake_q(wake_q),
        .ctrl_sleep_q(ctrl_sleep_q), .keep_clock_q(keep_clock_q));
    nvmc_array_model i_array (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_start_q(cmd_start_q),
        .array_done(array_done));

    always #20 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Tasks and monitor
    // ----------------------------------------
    task automatic wrap_up;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // An edge always passes before setup, so psel is never driven twice in one step
    task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [2:0] c);
        @(posedge clk_sys);
        unlock_key <= 1'b1;
        @(posedge clk_sys);
        unlock_key <= 1'b0;
        apb(1'b1, IDX_CMD, {5'h00, c});
        tick(3);
    endtask
    task automatic wait_idle;
        apb(1'b0, IDX_STAT, 8'h00);
        while (rd[1:0] !== 2'b00) apb(1'b0, IDX_STAT, 8'h00);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cmd_start_q === 1'b1) begin
            n_start++;
            last_code = cmd_code_q;
            last_ee = cmd_eeprom_q;
            last_incl = cmd_ee_incl_q;
        end
        if (buf_clear_q === 1'b1) n_clr++;
        if (cpu_halt_q === 1'b1) n_halt++;
        if (cyc == 30000) begin
            n_mismatch++;
            wrap_up;
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        tick(20);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, rows[i].wd);
            apb(1'b0, rows[i].idx, 8'h00);
            chk({8'h00, rd}, {8'h00, rows[i].exp});
        end
        chk(fuse_data_q, 16'h3CA5);
        chk(target_addr_q, 16'hC35A);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 8'h00);
            chk({8'h00, rd}, (regs[i] == IDX_IFLAG) ? 16'h0001 : 16'h0000);
        end
        apb(1'b0, 4'h5, 8'h00);
        chk({er, 7'h00, rd}, 16'h8000);
        s = n_start;
        apb(1'b1, IDX_CMD, 8'h02);
        tick(3);
        chk(16'(n_start - s), 16'h0000);
        buf_load_addr <= 16'h1410;
        buf_load <= 1'b1;
        tick(1);
        buf_load <= 1'b0;
        tick(2);
        chk(target_addr_q, 16'h1410);
        s = n_start;
        cmd(CMD_PAGE_ERASE);
        chk(16'(n_start - s), 16'h0001);
        chk({12'h000, last_code, last_ee}, {12'h000, CMD_PAGE_ERASE, 1'b1});
        sleep_req <= 1'b1;
        sleep_mode <= SLP_POWERDOWN;
        apb(1'b1, IDX_IEN, 8'h01);
        apb(1'b0, IDX_STAT, 8'h00);
        chk({14'h0000, rd[1], keep_clock_q}, 16'h0003);
        // Only while the EEPROM is busy can a cleared flag be seen low
        apb(1'b1, IDX_IFLAG, 8'h01);
        apb(1'b0, IDX_IFLAG, 8'h00);
        chk({14'h0000, rd[0], irq_q}, 16'h0000);
        wait_idle;
        tick(3);
        chk({13'h0000, ctrl_sleep_q, keep_clock_q, irq_q}, 16'h0005);
        apb(1'b1, IDX_IFLAG, 8'h01);
        tick(2);
        chk({15'h0000, irq_q}, 16'h0001);
        for (int m = 0; m < 3; m++) begin
            sleep_mode <= 2'(m);
            tick(3);
            chk({15'h0000, wake_q}, (m == 0) ? 16'h0001 : 16'h0000);
        end
        apb(1'b1, IDX_IEN, 8'h00);
        tick(2);
        chk({15'h0000, irq_q}, 16'h0000);
        h = n_clr;
        sleep_req <= 1'b0;
        tick(4);
        chk(16'(n_clr - h), 16'h0001);
        s = n_start;
        unlock_key <= 1'b1;
        tick(1);
        unlock_key <= 1'b0;
        repeat (4) begin
            tick(1);
            instr_retire <= 1'b1;
            tick(1);
            instr_retire <= 1'b0;
        end
        apb(1'b1, IDX_CMD, 8'h06);
        tick(3);
        chk(16'(n_start - s), 16'h0000);
        h = n_halt;
        s = n_clr;
        cmd(CMD_BUF_CLEAR);
        tick(8);
        chk(16'(n_clr - s), 16'h0001);
        chk(16'(n_halt - h), 16'h0007);
        for (int k = 0; k < 3; k++) begin
            eeprom_preserve_fuse <= (k == 1);
            s = n_start;
            cmd((k == 0) ? CMD_EE_ERASE : CMD_FULL_ERASE);
            chk({14'h0000, 1'(n_start - s), last_incl}, {14'h0000, 1'b1, k != 1});
            wait_idle;
        end
        for (int k = 0; k < 2; k++) begin
            dbg_port_sel <= k[0];
            s = n_start;
            cmd(CMD_FUSE_PROG);
            chk(16'(n_start - s), 16'(k));
            apb(1'b0, IDX_STAT, 8'h00);
            chk({14'h0000, rd[1:0]}, 16'(k));
            wait_idle;
        end
        dbg_port_sel <= 1'b0;
        buf_mixed <= 1'b1;
        cmd(CMD_PAGE_WRITE);
        apb(1'b0, IDX_STAT, 8'h00);
        chk({13'h0000, rd[2:0]}, 16'h0004);
        buf_mixed <= 1'b0;
        apb(1'b1, IDX_PROT, 8'h01);
        apb(1'b1, IDX_PROT, 8'h00);
        apb(1'b0, IDX_PROT, 8'h00);
        chk({8'h00, rd}, 16'h0001);
        apb(1'b1, IDX_ADDR_H, 8'h90);
        apb(1'b1, IDX_ADDR_L, 8'h00);
        cmd(CMD_ERASE_WRITE);
        apb(1'b0, IDX_STAT, 8'h00);
        chk({13'h0000, rd[2:0]}, 16'h0004);
        // Lock is written while fetching from boot code, so it must stay dormant
        apb(1'b1, IDX_PROT, 8'h02);
        tick(2);
        chk({8'h00, rd_data_q}, 16'h005E);
        fetch_addr <= 16'h9000;
        tick(3);
        chk({8'h00, rd_data_q}, 16'h0000);
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(2);
        chk({8'h00, rd_data_q}, 16'h005E);
        // Fetch is outside the boot section now, so the lock write must be refused
        apb(1'b1, IDX_PROT, 8'h02);
        apb(1'b0, IDX_PROT, 8'h00);
        chk({8'h00, rd}, 16'h0000);
        wrap_up;
    end
endmodule
`default_nettype wire
